// ===== hdl/cid_regs.vh
// Purpose: constants for the interrupt dispatch unit
// Assumes: byte addresses on a 32-bit apb bus
// Notes: one aligned word per register
`ifndef CID_REGS_VH
`define CID_REGS_VH
`define CID_OFS_CSR 8'h00
`define CID_OFS_IER 8'h04
`define CID_OFS_IFR 8'h08
`define CID_OFS_ICR 8'h0C
`define CID_OFS_VTP 8'h10
`define CID_OFS_IRP 8'h14
`define CID_OFS_NRP 8'h18
`define CID_GIE_BIT 0
`define CID_PREVIOUS_GLOBAL_ENABLE_BIT 1
`define CID_NONMASKABLE_ENABLE_BIT 1
`define CID_NMI_NUM 4'h1
`define CID_FIRST_MASKABLE 4
`define CID_NUM_LSB 5
`define CID_BASE_LSB 10
`define CID_FP_BYTES 32'h0000_0020
`define CID_DRAIN_CYCLES 3'h4
`define CID_GIE_RST 1'b0
`define CID_PREVIOUS_GLOBAL_ENABLE_RST 1'b0
`define CID_PTR_RST 32'h0000_0000
`define CID_IER_RST 16'h0001
`define CID_VTP_RST 22'h000000
`define CID_SEL_A1 3'h0
`define CID_SEL_A2 3'h1
`define CID_SEL_B0 3'h2
`define CID_SEL_B1 3'h3
`define CID_SEL_B2 3'h4
`endif

// ===== hdl/cid_dispatch.v
// Purpose: interrupt dispatch for a vliw dsp core, registers over apb
// Assumes: all inputs synchronous to clk; core reports stalls and branch shadows
// Notes: no wait states on apb; pready is always high
// Notes: read data is a snapshot taken in the setup cycle of each transfer
// Notes: flag edges are seen every clock, takes only on unstalled cpu cycles
// Notes: the return pointers are plain registers; software saves them to nest
// Contract
// - packets already in first execute stage finish through the fifth stage
// - packets not yet in first execute stage are annulled and refetched later
// - after return, earlier results are complete with no delay slot left
// - nmi preempts a maskable service routine
// - during nmi service no nmi and no maskable interrupt is taken
// - entry disables maskables; setting global enable again allows nesting
// - table pointer read gives vector packet address with pending number
// - one-hot write to clear register clears that flag bit
// - global enable bit in control status gates all maskable interrupts
// - table of sixteen packets, 256-word aligned, room for 32 entries
// - vector base comes from the table pointer register
// - each fetch packet holds at most eight words
// - branch shadow past a vector packet runs into the next packet
// - cpu cycles end on clock edges; stalls stretch a cpu cycle
// - traps are predicated on A1, A2, B0, B1 or B2
// - displacement branch target uses a 21-bit offset
// - results are hidden during delay slots after first execute stage
// - maskable take copies global enable to previous enable, then clears it
// - nmi take clears the nonmaskable enable bit
// - first annulled packet address saved in nmi or irq return pointer
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "cid_regs.vh"
module cid_dispatch (
   input wire clk,
   input wire arst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire nmi_line,
   input wire [15:4] maskable_irq_lines,
   input wire cpu_stall,
   input wire branch_shadow,
   input wire [31:0] resume_addr,
   input wire ret_irq,
   input wire ret_nmi,
   input wire fetch_next,
   input wire trap_req,
   input wire [2:0] trap_cond_sel,
   input wire [31:0] trap_pc,
   input wire [20:0] trap_disp,
   input wire cond_a1,
   input wire cond_a2,
   input wire cond_b0,
   input wire cond_b1,
   input wire cond_b2,
   output wire annul_pre_e1,
   output wire hold_fetch,
   output reg irq_ack,
   output reg [3:0] irq_number,
   output reg redirect,
   output reg [31:0] fetch_addr,
   output reg results_final,
   output reg trap_fire,
   output reg [31:0] trap_target
);

   // states of the take sequence; drain and vector both keep fetch held
   localparam ST_IDLE = 2'h0;
   localparam ST_DRAIN = 2'h1;
   localparam ST_VECTOR = 2'h2;

   // sequence state, enables, flags and saved pointers
   reg [1:0] state;
   reg [2:0] drain_cnt;
   reg global_irq_enable;
   reg previous_global_enable;
   reg [15:0] irq_enable_register;
   reg [15:0] irq_flag_register;
   reg [21:0] vtp_base;
   reg [31:0] irq_return_pointer;
   reg [31:0] nmi_return_pointer;
   reg [15:0] line_d;
   reg [3:0] take_num;
   reg [3:0] hp_num;
   reg hp_any;
   reg take;
   reg [15:0] next_ifr;
   reg [31:0] next_prdata;
   wire [15:0] pend_en;
   integer i;
   genvar g;

   // address decode used for both read mux and write strobes
   // offsets not listed fall into index 7, which answers with an error
   function [2:0] reg_index;
      input [7:0] a;
      begin
         if (a == `CID_OFS_CSR) reg_index = 3'h0;
         else if (a == `CID_OFS_IER) reg_index = 3'h1;
         else if (a == `CID_OFS_IFR) reg_index = 3'h2;
         else if (a == `CID_OFS_ICR) reg_index = 3'h3;
         else if (a == `CID_OFS_VTP) reg_index = 3'h4;
         else if (a == `CID_OFS_IRP) reg_index = 3'h5;
         else if (a == `CID_OFS_NRP) reg_index = 3'h6;
         else reg_index = 3'h7;
      end
   endfunction

   // predicate select over the five condition registers
   // selects five to seven name no register and never let a trap through
   function cond_pick;
      input [2:0] s;
      input c0, c1, c2, c3, c4;
      begin
         if (s == `CID_SEL_A1) cond_pick = c0;
         else if (s == `CID_SEL_A2) cond_pick = c1;
         else if (s == `CID_SEL_B0) cond_pick = c2;
         else if (s == `CID_SEL_B1) cond_pick = c3;
         else if (s == `CID_SEL_B2) cond_pick = c4;
         else cond_pick = 1'b0;
      end
   endfunction

   // bus qualifiers and the flag view of the lines; bits 0, 2 and 3 have no line
   wire [2:0] idx = reg_index(paddr);
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire [15:0] lines = {maskable_irq_lines, 2'b00, nmi_line, 1'b0};
   wire [15:0] rises = lines & ~line_d;
   wire nonmaskable_enable = irq_enable_register[`CID_NONMASKABLE_ENABLE_BIT];

   // no wait states: every register answers in the access cycle
   // unmapped offsets answer with an error instead of aliasing onto a real register
   assign pready = 1'b1;
   assign pslverr = acc & (idx == 3'h7);

   // pending and enabled, one bit per flag; the nmi bit ignores its enable bit here
   // because that bit is nonmaskable_enable, and nonmaskable_enable gates every take below, not just the nmi
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_pend
         if (g == 1) begin : g_nmi
            assign pend_en[g] = irq_flag_register[g];
         end else begin : g_mask
            assign pend_en[g] = irq_flag_register[g] & irq_enable_register[g];
         end
      end
   endgenerate

   // highest pending: nmi first, then lowest numbered maskable line
   // scanning downwards lets the last hit, the lowest number, win
   always @* begin
      hp_any = 1'b0;
      hp_num = 4'h0;
      for (i = 15; i >= 1; i = i - 1) begin
         if (pend_en[i]) begin
            hp_any = 1'b1;
            hp_num = i[3:0];
         end
      end
   end

   // take decision, only at a cpu cycle boundary outside branch shadows
   // a take inside a shadow would save a return address that the branch abandons
   always @* begin
      take = 1'b0;
      take_num = hp_num;
      if (state == ST_IDLE && !cpu_stall && !branch_shadow && nonmaskable_enable && hp_any) begin
         if (hp_num == `CID_NMI_NUM) take = 1'b1;
         else take = global_irq_enable;
      end
   end

   // packets not yet in the first execute stage are squashed on the take
   // fetch stays held from the take until the vector packet is issued
   assign annul_pre_e1 = take;
   assign hold_fetch = (state != ST_IDLE);

   // edge history for flag setting; detection runs every clock, not cpu cycle
   // a line already high when reset ends sets its flag on the first clock
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         line_d <= 16'h0000;
      end else begin
         line_d <= lines;
      end
   end

   // flag update: new edge wins over software clear and over take clear
   // so an edge that lands together with a clear is never lost
   always @* begin
      next_ifr = irq_flag_register;
      if (wr && idx == 3'h3) next_ifr = next_ifr & ~pwdata[15:0];
      if (take) next_ifr[take_num] = 1'b0;
      next_ifr = (next_ifr | rises) & 16'hFFF2;
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_flag_register <= 16'h0000;
      end else begin
         irq_flag_register <= next_ifr;
      end
   end

   // sequence: drain in-flight packets, then vector
   // the drain counts unstalled cycles only, so stalls stretch it and never shorten it
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         drain_cnt <= 3'h0;
         irq_number <= 4'h0;
         irq_ack <= 1'b0;
         redirect <= 1'b0;
         results_final <= 1'b0;
      end else begin
         irq_ack <= 1'b0;
         redirect <= 1'b0;
         results_final <= 1'b0;
         case (state)
            // wait for a take; the number is latched here and holds until the next one
            ST_IDLE: begin
               if (take) begin
                  irq_number <= take_num;
                  drain_cnt <= `CID_DRAIN_CYCLES;
                  state <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               // stalled clocks do not count: only cpu cycles move E2..E5
               if (!cpu_stall) begin
                  if (drain_cnt == 3'h1) begin
                     // results now committed, no delay slot survives the return
                     results_final <= 1'b1;
                     state <= ST_VECTOR;
                  end
                  drain_cnt <= drain_cnt - 3'h1;
               end
            end
            // vector on the next unstalled cycle; number then holds, address holds until fetch_next
            ST_VECTOR: begin
               if (!cpu_stall) begin
                  irq_ack <= 1'b1;
                  redirect <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // fetch address: vector packet on redirect, then packet by packet
   // bit 9 stays zero: only sixteen of the thirty-two reserved slots are reachable
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_addr <= 32'h0000_0000;
      end else if (state == ST_VECTOR && !cpu_stall) begin
         fetch_addr <= {vtp_base, 1'b0, irq_number, 5'h00};
      end else if (fetch_next && !cpu_stall) begin
         // eight words per packet; shadows run on into the next packet
         fetch_addr <= fetch_addr + `CID_FP_BYTES;
      end
   end

   // control state: enables, return pointers and table base
   // a take in the same clock as a software write wins, so a save is never lost
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         global_irq_enable <= `CID_GIE_RST;
         previous_global_enable <= `CID_PREVIOUS_GLOBAL_ENABLE_RST;
         irq_enable_register <= `CID_IER_RST;
         vtp_base <= `CID_VTP_RST;
         irq_return_pointer <= `CID_PTR_RST;
         nmi_return_pointer <= `CID_PTR_RST;
      end else begin
         if (wr) begin
            if (idx == 3'h0) begin
               global_irq_enable <= pwdata[`CID_GIE_BIT];
               previous_global_enable <= pwdata[`CID_PREVIOUS_GLOBAL_ENABLE_BIT];
            end
            if (idx == 3'h1) irq_enable_register <= {pwdata[15:4], 2'b00, pwdata[1], 1'b1};
            if (idx == 3'h4) vtp_base <= pwdata[31:10];
            if (idx == 3'h5) irq_return_pointer <= pwdata;
            if (idx == 3'h6) nmi_return_pointer <= pwdata;
         end
         // a return restores what the take saved; a take in the same clock
         // still wins because it is written last
         if (ret_irq) global_irq_enable <= previous_global_enable;
         if (ret_nmi) irq_enable_register[`CID_NONMASKABLE_ENABLE_BIT] <= 1'b1;
         // enables and return pointer are saved at the take edge, before the drain
         if (take) begin
            if (take_num == `CID_NMI_NUM) begin
               irq_enable_register[`CID_NONMASKABLE_ENABLE_BIT] <= 1'b0;
               nmi_return_pointer <= resume_addr;
            end else begin
               previous_global_enable <= global_irq_enable;
               global_irq_enable <= 1'b0;
               irq_return_pointer <= resume_addr;
            end
         end
      end
   end

   // software trap: predicated branch with 21-bit word displacement
   // the target is computed every clock so it is ready whatever the predicate says
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trap_fire <= 1'b0;
         trap_target <= 32'h0000_0000;
      end else begin
         trap_fire <= trap_req & cond_pick(trap_cond_sel, cond_a1, cond_a2,
                                           cond_b0, cond_b1, cond_b2);
         trap_target <= trap_pc + {{9{trap_disp[20]}}, trap_disp, 2'b00};
      end
   end

   // read mux; pointer read carries the number of the highest pending line
   // the clear register is write-only and reads as zero, like an unmapped offset
   always @* begin
      next_prdata = 32'h0000_0000;
      if (idx == 3'h0) next_prdata = {30'h0, previous_global_enable, global_irq_enable};
      else if (idx == 3'h1) next_prdata = {16'h0, irq_enable_register};
      else if (idx == 3'h2) next_prdata = {16'h0, irq_flag_register};
      else if (idx == 3'h4) next_prdata = {vtp_base, 1'b0, hp_num, 5'h00};
      else if (idx == 3'h5) next_prdata = irq_return_pointer;
      else if (idx == 3'h6) next_prdata = nmi_return_pointer;
   end

   // read data is captured in the setup cycle and stands through the access;
   // a flag that changes in the access cycle shows up on the next read
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= next_prdata;
      end
   end

endmodule // cid_dispatch

// ===== bench/cid_monitor.sv
// Purpose: port checker for cid_dispatch
// Assumes: no stall while draining
// Notes: bound below
`timescale 1ns/100ps
module cid_monitor (
   input wire clk,
   input wire arst_n,
   input wire cpu_stall,
   input wire ret_nmi,
   input wire trap_req,
   input wire [2:0] trap_cond_sel,
   input wire cond_a1,
   input wire cond_a2,
   input wire cond_b0,
   input wire cond_b1,
   input wire cond_b2,
   input wire annul_pre_e1,
   input wire hold_fetch,
   input wire irq_ack,
   input wire [3:0] irq_number,
   input wire redirect,
   input wire [31:0] fetch_addr,
   input wire results_final,
   input wire trap_fire
);
   reg in_nmi;
   wire [7:0] cv;
   wire pred;
   // selects 5..7 name no register, so they never fire
   assign cv = {3'h0, cond_b2, cond_b1, cond_b0, cond_a2, cond_a1};
   assign pred = cv[trap_cond_sel];
   // nmi service runs from its vectoring to its return
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         in_nmi <= 1'b0;
      else if (irq_ack && irq_number == 4'h1)
         in_nmi <= 1'b1;
      else if (ret_nmi)
         in_nmi <= 1'b0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   ack_redir_a: assert property (irq_ack == redirect) else $error("ack redirect");
   vec_addr_a: assert property (irq_ack |-> fetch_addr[9:0] == {1'b0, irq_number, 5'h00})
      else $error("vector");
   take_gate_a: assert property (annul_pre_e1 |-> !cpu_stall && !hold_fetch) else $error("gate");
   drain_len_a: assert property (annul_pre_e1 ##1 !cpu_stall [*4] |=> results_final)
      else $error("drain long");
   drain_min_a: assert property (annul_pre_e1 |=> !results_final [*3]) else $error("drain short");
   ack_soon_a: assert property (results_final |-> ##[1:8] irq_ack) else $error("no ack");
   hold_on_a: assert property (annul_pre_e1 |=> hold_fetch [*4]) else $error("hold");
   nmi_excl_a: assert property (in_nmi |-> !annul_pre_e1) else $error("nmi nested");
   trap_pred_a: assert property (trap_fire == ($past(trap_req) && $past(pred))) else $error("trap");
   cover property (irq_ack && irq_number == 4'h1);
   cover property (results_final);
   cover property (trap_fire);
endmodule // cid_monitor
bind cid_dispatch cid_monitor u_mon (.*);

// ===== bench/cid_irq_src.sv
// Purpose: peripheral and pin interrupt sources
// Assumes: fire is a one-cycle request
// Notes: numbers 0, 2 and 3 drive nothing
`timescale 1ns/100ps
module cid_irq_src (
   input wire clk,
   input wire arst_n,
   input wire fire,
   input wire [3:0] num,
   output reg nmi_line,
   output reg [15:4] maskable_irq_lines
);
   // one-cycle pulse; only the rising edge matters
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nmi_line <= 1'b0;
         maskable_irq_lines <= 12'h000;
      end else begin
         nmi_line <= fire && num == 4'h1;
         maskable_irq_lines <= (fire && num > 4'h3) ? 12'h001 << (num - 4'h4) : 12'h000;
      end
   end
endmodule // cid_irq_src

// ===== bench/testbench.sv
// Purpose: self-checking bench for cid_dispatch
// Assumes: stalls only where a scenario raises them
// Notes: sources from cid_irq_src
`timescale 1ns/100ps
module testbench;
   reg clk, arst_n, psel, penable, pwrite, cpu_stall, branch_shadow, ret_irq, ret_nmi, fetch_next, trap_req, fire;
   reg cond_a1, cond_a2, cond_b0, cond_b1, cond_b2, serr;
   reg [7:0] paddr;
   reg [31:0] pwdata, resume_addr, trap_pc, rd;
   reg [20:0] trap_disp;
   reg [2:0] trap_cond_sel;
   reg [3:0] num;
   wire [31:0] prdata, fetch_addr, trap_target;
   wire [15:4] maskable_irq_lines;
   wire [3:0] irq_number;
   wire pready, pslverr, nmi_line, annul_pre_e1, hold_fetch, irq_ack, redirect, results_final, trap_fire;
   integer err_total, cmp_count, k;
   cid_dispatch uut (.*);
   cid_irq_src src (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task tally_and_finish;
      begin
         $display("compares %0d mismatches %0d", cmp_count, err_total);
         if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input string what, input [31:0] e, input [31:0] g);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            $display("ERROR %0s exp %h got %h", what, e, g);
            err_total = err_total + 1;
         end
      end
   endtask
   // request held until pready is seen at a rising edge
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 16);
         if (n == 16) begin
            chk("pready", 32'h1, 32'h0);
            tally_and_finish;
         end
         rd = prdata;
         serr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task pulse(input [3:0] n);
      begin
         @(posedge clk);
         fire <= 1'b1;
         num <= n;
         @(posedge clk);
         fire <= 1'b0;
      end
   endtask
   task quiet(input integer c);
      begin
         repeat (c) begin
            @(posedge clk);
            chk("no_take", 32'h0, irq_ack);
         end
      end
   endtask
   task wait_ack(input [3:0] n, input [31:0] vec);
      integer t;
      begin
         t = 0;
         do begin
            @(posedge clk);
            t = t + 1;
         end while (irq_ack !== 1'b1 && t < 40);
         if (t == 40) begin
            chk("irq_ack", 32'h1, 32'h0);
            tally_and_finish;
         end
         chk("irq_number", n, irq_number);
         chk("fetch_addr", vec, fetch_addr);
         chk("redirect", 32'h1, redirect);
      end
   endtask
   task s_regs;
      begin
         apb(1'h0, 8'h00, 32'h0);
         chk("csr", 32'h0, rd);
         apb(1'h0, 8'h04, 32'h0);
         chk("ier", 32'h1, rd);
         apb(1'h1, 8'h14, 32'hA5C3_0F0C);
         apb(1'h0, 8'h14, 32'h0);
         chk("irp", 32'hA5C3_0F0C, rd);
         apb(1'h0, 8'h40, 32'h0);
         chk("slverr", 32'h1, serr);
      end
   endtask
   task s_take;
      begin
         resume_addr <= 32'h0000_1000;
         apb(1'h1, 8'h10, 32'h0000_0400);
         apb(1'h1, 8'h04, 32'h0000_0062);
         apb(1'h1, 8'h00, 32'h1);
         branch_shadow <= 1'b1;
         pulse(4'h5);
         quiet(12);
         branch_shadow <= 1'b0;
         cpu_stall <= 1'b1;
         quiet(3);
         cpu_stall <= 1'b0;
         wait_ack(4'h5, 32'h0000_04A0);
         apb(1'h0, 8'h00, 32'h0);
         chk("csr", 32'h2, rd);
         apb(1'h0, 8'h14, 32'h0);
         chk("irp", 32'h0000_1000, rd);
      end
   endtask
   task s_nest;
      begin
         resume_addr <= 32'h0000_2000;
         pulse(4'h6);
         quiet(10);
         apb(1'h0, 8'h10, 32'h0);
         chk("vtp", 32'h0000_04C0, rd);
         pulse(4'h1);
         wait_ack(4'h1, 32'h0000_0420);
         apb(1'h0, 8'h18, 32'h0);
         chk("nrp", 32'h0000_2000, rd);
         apb(1'h1, 8'h00, 32'h1);
         quiet(10);
         ret_nmi <= 1'b1;
         @(posedge clk);
         ret_nmi <= 1'b0;
         wait_ack(4'h6, 32'h0000_04C0);
         fetch_next <= 1'b1;
         @(posedge clk);
         fetch_next <= 1'b0;
         @(posedge clk);
         chk("fetch_next", 32'h0000_04E0, fetch_addr);
      end
   endtask
   task s_clear;
      begin
         pulse(4'h7);
         apb(1'h0, 8'h08, 32'h0);
         chk("ifr", 32'h80, rd);
         apb(1'h1, 8'h0C, 32'h80);
         apb(1'h0, 8'h08, 32'h0);
         chk("ifr", 32'h0, rd);
         ret_irq <= 1'b1;
         @(posedge clk);
         ret_irq <= 1'b0;
         apb(1'h0, 8'h00, 32'h0);
         chk("csr", 32'h3, rd);
      end
   endtask
   // each select with its register false, then true
   task s_trap;
      begin
         trap_pc <= 32'h0000_8000;
         trap_disp <= 21'h1F_FFFE;
         for (k = 0; k < 10; k = k + 1) begin
            @(posedge clk);
            {cond_b2, cond_b1, cond_b0, cond_a2, cond_a1} <= (5'h01 << k[3:1]) ^ {5{~k[0]}};
            trap_cond_sel <= k[3:1];
            trap_req <= 1'b1;
            @(posedge clk);
            trap_req <= 1'b0;
            #1;
            chk("trap_fire", k[0], trap_fire);
         end
         chk("trap_target", 32'h0000_7FF8, trap_target);
      end
   endtask
   initial begin
      err_total = 0;
      cmp_count = 0;
      {arst_n, psel, penable, pwrite, cpu_stall, branch_shadow, ret_irq, ret_nmi, fetch_next, trap_req, fire} = 11'h0;
      {cond_a1, cond_a2, cond_b0, cond_b1, cond_b2, trap_cond_sel, num, paddr} = 20'h0;
      {pwdata, resume_addr, trap_pc, trap_disp} = 117'h0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      s_regs;
      s_take;
      s_nest;
      s_clear;
      s_trap;
      tally_and_finish;
   end
endmodule // testbench
